/* hdl/gpb_port.sv */
//Contract
//RULE_01: direction bit one turns the pin driver off, pin is input.
//RULE_02: direction bit zero enables driver with latch or peripheral value.
//RULE_03: data read returns sampled pins; write only loads the output latch.
//RULE_04: data writes are read-modify-write; untargeted latch bits take pin values.
//RULE_05: analog-selected pins read zero on every digital read.
//RULE_06: direction bits govern drivers even for analog pins.
//RULE_07: software keeps analog pins set as inputs.
//RULE_08: driving needs cleared direction; reads then show real pin state.
//RULE_09: analog-select bits reset to analog; software clears them for digital.
//RULE_10: per-pin change enables, all cleared at reset.
//RULE_11: per-pin weak pull-up, removed while pin is an output. Code has no pull-up on pin 0 (MASK_WPU).
//RULE_12: pull-ups disabled after reset by the global pull-up control.
//RULE_13: pin zero is open-drain, only pulls low.
//RULE_14: with several outputs enabled, highest priority function owns the pin.
//RULE_15: priority: port latch lowest, multiplexed peripheral highest on pins 0,1,4,7.
//RULE_16: output functions still drive pins in analog mode.
//RULE_17: bits 3 and 2 unimplemented, ignore writes, read zero.
//RULE_18: small package has pins 0 and 1; large adds pins 7 to 4.
//RULE_19: software avoids port use while a muxed peripheral is enabled.
//RULE_20: enabled pins compared with last-read value; mismatches set change flag. Code also reloads the compare value on data writes.
//RULE_21: pull-up on only if global allows, input, enabled, not analog.
//RULE_22: pin inputs pass a two-stage synchroniser before use.
`timescale 1ns/1ns
`default_nettype none
module gpb_port
   import gpb_pkg::*;
#(
   parameter bit LARGE_PKG = 1'b1
) (
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // register bus
   input  wire gpb_axi_req_t axi_req,
   output gpb_axi_rsp_t      axi_rsp,
   // multiplexed peripheral outputs
   input  wire gpb_periph_t  periph,
   // pins
   input  wire logic [7:0]   pin_in,
   output logic [7:0]        pin_out,
   output logic [7:0]        pin_oe,
   output logic [7:0]        pullup_on,
   // change flag
   output logic              pin_change_flag
);

   localparam logic [7:0] IMPL = LARGE_PKG ? MASK_LARGE : MASK_SMALL;

   typedef struct packed {
      logic [7:0]  latch;
      logic [7:0]  dir;
      logic [7:0]  ansel;
      logic [7:0]  wpu;
      logic [7:0]  ioc;
      logic        pu_dis;
      logic        flag;
      logic [7:0]  last_rd;
      logic [7:0]  sync1;
      logic [7:0]  sync2;
      logic [7:0]  pout;
      logic [7:0]  poe;
      logic [7:0]  pull;
      logic        aw_got;
      logic        w_got;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      gpb_axi_rsp_t rsp;
   } gpb_state_t;

   gpb_state_t st_reg;
   gpb_state_t st_next;

   // =================================================================
   // combinational helpers
   // =================================================================
   logic [7:0] pin_rd;
   logic [7:0] drive_val;
   logic [7:0] mismatch;

   // analog pins read zero
   // RULE_05 analog reads zero
   // RULE_08 reads show pins
   assign pin_rd = st_reg.sync2 & ~st_reg.ansel & IMPL;

   // peripheral overrides latch where enabled, on pins 0,1,4,7 only
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_pin
         // RULE_14 highest priority wins
         // RULE_15 peripheral above latch
         assign drive_val[g] = (MASK_PERIPH[g] & periph.en[g]) ? periph.val[g]
                                                               : st_reg.latch[g];
      end
   endgenerate

   // RULE_20 compare with last read
   assign mismatch = (st_reg.sync2 ^ st_reg.last_rd) & st_reg.ioc & ~st_reg.ansel & IMPL;

   // =================================================================
   // next state
   // =================================================================
   always_comb begin
      logic [7:0] wb;
      logic [7:0] wa;
      logic [7:0] ra;
      logic       rd_data;
      logic       wr_data;
      st_next = st_reg;
      wb      = st_reg.wdata[7:0];
      wa      = {st_reg.awaddr[7:2], 2'b00};
      ra      = {axi_req.araddr[7:2], 2'b00};
      rd_data = 1'b0;
      wr_data = 1'b0;

      // RULE_22 two-stage synchroniser
      st_next.sync1 = pin_in;
      st_next.sync2 = st_reg.sync1;

      // write channel capture, either order
      if (st_reg.rsp.awready && axi_req.awvalid) begin
         st_next.aw_got = 1'b1;
         st_next.awaddr = axi_req.awaddr;
      end
      if (st_reg.rsp.wready && axi_req.wvalid) begin
         st_next.w_got = 1'b1;
         st_next.wdata = axi_req.wdata;
         st_next.wstrb = axi_req.wstrb;
      end
      if (st_reg.rsp.bvalid && axi_req.bready) begin
         st_next.rsp.bvalid = 1'b0;
      end

      // perform the write
      if (st_reg.aw_got && st_reg.w_got && !st_reg.rsp.bvalid) begin
         st_next.aw_got     = 1'b0;
         st_next.w_got      = 1'b0;
         st_next.rsp.bvalid = 1'b1;
         st_next.rsp.bresp  = RESP_OKAY;
         if (wa == OFF_DATA) begin
            wr_data = 1'b1;
            // RULE_04 read-modify-write
            // RULE_17 unimplemented bits stay zero
            st_next.latch = (st_reg.wstrb[0] ? wb : pin_rd) & IMPL;
         end else if (wa == OFF_DIR) begin
            if (st_reg.wstrb[0]) begin
               st_next.dir = wb & IMPL;
            end
         end else if (wa == OFF_ANSEL) begin
            if (st_reg.wstrb[0]) begin
               st_next.ansel = wb & MASK_ANSEL & IMPL;
            end
         end else if (wa == OFF_WPU) begin
            if (st_reg.wstrb[0]) begin
               st_next.wpu = wb & MASK_WPU & IMPL;
            end
         end else if (wa == OFF_IOC) begin
            if (st_reg.wstrb[0]) begin
               st_next.ioc = wb & IMPL;
            end
         end else if (wa == OFF_CTRL) begin
            if (st_reg.wstrb[0]) begin
               st_next.pu_dis = wb[CTRL_PU_DIS];
               if (wb[CTRL_FLAG]) begin
                  st_next.flag = 1'b0;
               end
            end
         end else begin
            st_next.rsp.bresp = RESP_SLVERR;
         end
      end

      // read channel
      if (st_reg.rsp.rvalid && axi_req.rready) begin
         st_next.rsp.rvalid = 1'b0;
      end
      if (st_reg.rsp.arready && axi_req.arvalid) begin
         st_next.rsp.rvalid = 1'b1;
         st_next.rsp.rresp  = RESP_OKAY;
         st_next.rsp.rdata  = ZERO32;
         if (ra == OFF_DATA) begin
            rd_data = 1'b1;
            // RULE_03 read returns pins
            st_next.rsp.rdata[7:0] = pin_rd;
         end else if (ra == OFF_DIR) begin
            st_next.rsp.rdata[7:0] = st_reg.dir;
         end else if (ra == OFF_ANSEL) begin
            st_next.rsp.rdata[7:0] = st_reg.ansel;
         end else if (ra == OFF_WPU) begin
            st_next.rsp.rdata[7:0] = st_reg.wpu;
         end else if (ra == OFF_IOC) begin
            st_next.rsp.rdata[7:0] = st_reg.ioc;
         end else if (ra == OFF_CTRL) begin
            st_next.rsp.rdata[CTRL_PU_DIS] = st_reg.pu_dis;
            st_next.rsp.rdata[CTRL_FLAG]   = st_reg.flag;
         end else begin
            st_next.rsp.rresp = RESP_SLVERR;
         end
      end

      // access to data ends the mismatch
      if (rd_data || wr_data) begin
         st_next.last_rd = st_reg.sync2 & IMPL;
      end
      // RULE_20 set wins over clear
      if (|mismatch) begin
         st_next.flag = 1'b1;
      end

      st_next.rsp.awready = !st_next.aw_got && !st_next.rsp.bvalid;
      st_next.rsp.wready  = !st_next.w_got && !st_next.rsp.bvalid;
      st_next.rsp.arready = !st_next.rsp.rvalid;

      // RULE_01 input disables driver
      // RULE_02 output enables driver
      // RULE_06 direction governs analog pins
      // RULE_16 output in analog mode
      st_next.poe  = ~st_reg.dir & IMPL;
      st_next.pout = drive_val & IMPL;
      // RULE_13 open-drain pin zero
      st_next.poe[OD_PIN]  = ~st_reg.dir[OD_PIN] & ~drive_val[OD_PIN];
      st_next.pout[OD_PIN] = 1'b0;
      // RULE_11 pull-up off for outputs
      // RULE_21 pull-up qualification
      st_next.pull = {8{~st_reg.pu_dis}} & st_reg.dir & st_reg.wpu & ~st_reg.ansel & IMPL;
   end

   // =================================================================
   // state register
   // =================================================================
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg             <= '0;
         st_reg.latch       <= RST_LATCH;
         // RULE_18 package-dependent bits
         st_reg.dir         <= RST_DIR & IMPL;
         // RULE_09 analog after reset
         st_reg.ansel       <= RST_ANSEL & MASK_ANSEL & IMPL;
         st_reg.wpu         <= RST_WPU & MASK_WPU & IMPL;
         // RULE_10 change enables cleared
         st_reg.ioc         <= RST_IOC;
         // RULE_12 pull-ups globally off
         st_reg.pu_dis      <= RST_PU_DIS;
         st_reg.rsp.awready <= 1'b1;
         st_reg.rsp.wready  <= 1'b1;
         st_reg.rsp.arready <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign axi_rsp         = st_reg.rsp;
   assign pin_out         = st_reg.pout;
   assign pin_oe          = st_reg.poe;
   assign pullup_on       = st_reg.pull;
   assign pin_change_flag = st_reg.flag;

   // =================================================================
   // checks
   // =================================================================
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic [7:0] dir_q;
   assign dir_q = st_reg.dir;

   sequence s_rd_data;
      axi_req.arvalid && st_reg.rsp.arready
      && ({axi_req.araddr[7:2], 2'b00} == OFF_DATA);
   endsequence

   sequence s_wr_data;
      st_reg.aw_got && st_reg.w_got && !st_reg.rsp.bvalid
      && ({st_reg.awaddr[7:2], 2'b00} == OFF_DATA);
   endsequence

   property p_dir_in;
      1'b1 |=> ((pin_oe & $past(dir_q)) == 8'h00);
   endproperty
   a_dir_in: assert property (p_dir_in) else $error("driver on for input pin"); // RULE_01

   property p_dir_out;
      !dir_q[1] && LARGE_PKG |=> pin_oe[1];
   endproperty
   a_dir_out: assert property (p_dir_out) else $error("driver off for output pin"); // RULE_02

   property p_rd_pins;
      logic [7:0] v;
      (s_rd_data, v = pin_rd) |=> axi_rsp.rvalid && (axi_rsp.rdata[7:0] == v)
                                 && (axi_rsp.rdata[31:8] == 24'h000000);
   endproperty
   a_rd_pins: assert property (p_rd_pins) else $error("data read not pin state"); // RULE_03

   property p_rmw;
      logic [7:0] v;
      ((s_wr_data and !st_reg.wstrb[0]), v = pin_rd) |=> st_reg.latch == v;
   endproperty
   a_rmw: assert property (p_rmw) else $error("latch not refilled from pins"); // RULE_04

   property p_analog_zero;
      s_rd_data |=> ((axi_rsp.rdata[7:0] & $past(st_reg.ansel)) == 8'h00);
   endproperty
   a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero"); // RULE_05

   property p_ioc_reset;
      $rose(aresetn) |-> st_reg.ioc == RST_IOC && st_reg.pu_dis;
   endproperty
   a_ioc_reset: assert property (p_ioc_reset) else $error("enables not cleared"); // RULE_10

   property p_od;
      pin_out[OD_PIN] == 1'b0;
   endproperty
   a_od: assert property (p_od) else $error("open-drain pin driven high"); // RULE_13

   property p_prio;
      periph.en[7] && !dir_q[7] && LARGE_PKG |=> pin_oe[7] && pin_out[7] == $past(periph.val[7]);
   endproperty
   a_prio: assert property (p_prio) else $error("peripheral lost pin"); // RULE_15

   property p_unimpl;
      (st_reg.dir[3:2] == 2'b00) && (st_reg.latch[3:2] == 2'b00);
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented bits set"); // RULE_17

   property p_flag;
      (|mismatch) |=> pin_change_flag [*2];
   endproperty
   a_flag: assert property (p_flag) else $error("change flag not set"); // RULE_20

   property p_pull;
      1'b1 |=> ((pullup_on & ~$past(dir_q)) == 8'h00)
               && ((pullup_on & $past(st_reg.ansel)) == 8'h00);
   endproperty
   a_pull: assert property (p_pull) else $error("pull-up on output or analog"); // RULE_21

   property p_pull_on;
      LARGE_PKG && !st_reg.pu_dis && st_reg.dir[4] && st_reg.wpu[4] && !st_reg.ansel[4]
      |=> pullup_on[4];
   endproperty
   a_pull_on: assert property (p_pull_on) else $error("qualified pull-up not on"); // RULE_21

   property p_sync;
      $past(aresetn) |=> st_reg.sync2 == $past(pin_in, 2);
   endproperty
   a_sync: assert property (p_sync) else $error("pin synchroniser depth wrong"); // RULE_22

   property p_impl;
      ((pin_oe | pin_out | pullup_on) & ~IMPL) == 8'h00;
   endproperty
   a_impl: assert property (p_impl) else $error("absent pin driven or pulled"); // RULE_18

   property p_ansel_reset;
      $rose(aresetn) |-> st_reg.ansel == (RST_ANSEL & MASK_ANSEL & IMPL);
   endproperty
   a_ansel_reset: assert property (p_ansel_reset) else $error("analog select not reset"); // RULE_09

   property p_pull_reset;
      $rose(aresetn) |=> pullup_on == 8'h00;
   endproperty
   a_pull_reset: assert property (p_pull_reset) else $error("pull-up on after reset"); // RULE_12

   property p_analog_drive;
      !dir_q[1] && st_reg.ansel[1] |=> pin_oe[1];
   endproperty
   a_analog_drive: assert property (p_analog_drive) else $error("analog output not driven"); // RULE_06

   property p_prio_dac;
      periph.en[1] && !dir_q[1] |=> pin_oe[1] && (pin_out[1] == $past(periph.val[1]));
   endproperty
   a_prio_dac: assert property (p_prio_dac) else $error("dac output lost pin"); // RULE_16

endmodule
`default_nettype wire

/* common/gpb_pkg.sv */
package gpb_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_DATA   = 8'h00;
   localparam logic [7:0] OFF_DIR    = 8'h04;
   localparam logic [7:0] OFF_ANSEL  = 8'h08;
   localparam logic [7:0] OFF_WPU    = 8'h0C;
   localparam logic [7:0] OFF_IOC    = 8'h10;
   localparam logic [7:0] OFF_CTRL   = 8'h14;
   // implemented bit masks
   localparam logic [7:0] MASK_LARGE = 8'hF3;
   localparam logic [7:0] MASK_SMALL = 8'h03;
   localparam logic [7:0] MASK_WPU   = 8'hF2;
   localparam logic [7:0] MASK_ANSEL = 8'h72;
   localparam logic [7:0] MASK_PERIPH = 8'h93;
   // reset values
   localparam logic [7:0] RST_DIR    = 8'hFF;
   localparam logic [7:0] RST_ANSEL  = 8'hFF;
   localparam logic [7:0] RST_WPU    = 8'hFF;
   localparam logic [7:0] RST_IOC    = 8'h00;
   localparam logic [7:0] RST_LATCH  = 8'h00;
   localparam logic       RST_PU_DIS = 1'b1;
   // control register fields and the open-drain pin index
   localparam int CTRL_PU_DIS = 0;
   localparam int CTRL_FLAG   = 1;
   localparam int OD_PIN      = 0;
   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [31:0] ZERO32     = 32'h0000_0000;

   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } gpb_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } gpb_axi_rsp_t;

   typedef struct packed {
      logic [7:0] en;
      logic [7:0] val;
   } gpb_periph_t;
endpackage

/* tb/gpb_board.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// board circuitry on the port pins
module gpb_board (
   // clock
   input  wire logic       aclk,
   // device side
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] pullup_on,
   // board drivers
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   // level seen by the device
   output logic [7:0]      pin_in
);
   logic [7:0] float_reg = 8'h55;

   // undriven pins wander every cycle
   always_ff @(posedge aclk) begin
      float_reg <= ~float_reg;
   end

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe[i]) begin
            pin_in[i] = pin_out[i];
         end else if (ext_en[i]) begin
            pin_in[i] = ext_val[i];
         end else if (pullup_on[i]) begin
            pin_in[i] = 1'b1;
         end else begin
            pin_in[i] = float_reg[i];
         end
      end
   end
endmodule
`default_nettype wire

/* tb/gpb_port_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, got, exp) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module gpb_port_tb import gpb_pkg::*;;
   logic         aclk;
   logic         aresetn;
   gpb_axi_req_t req;
   gpb_axi_rsp_t rsp;
   gpb_periph_t  periph;
   logic [7:0]   pin_in, pin_out, pin_oe, pullup_on, ext_en, ext_val;
   logic         flag;
   int           failures;
   int           samples_checked;
   logic [7:0]   rst_addr [5] = '{OFF_DIR, OFF_ANSEL, OFF_WPU, OFF_IOC, OFF_CTRL};
   logic [7:0]   rst_val [5]  = '{8'hF3, 8'h72, 8'hF2, 8'h00, 8'h01};

   gpb_port #(.LARGE_PKG(1'b1)) DUT (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
      .axi_rsp(rsp), .periph(periph), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pullup_on(pullup_on), .pin_change_flag(flag));
   gpb_board board (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
      .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // ==========================================
   // bus and check tasks
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1,
                     input logic [1:0] er = RESP_OKAY);
      bit done;
      done = 1'b0;
      req.awaddr <= a;
      req.awvalid <= 1'b1;
      req.wdata <= {24'h000000, d};
      req.wstrb <= s;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      for (int n = 0; n < 64 && !done; n++) begin
         @(posedge aclk);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid) begin
            done = 1'b1;
            `CHK("bresp", rsp.bresp, er)
         end
      end
      if (!done) begin
         failures++;
         print_verdict();
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e,
                     input logic [1:0] er = RESP_OKAY);
      bit done;
      done = 1'b0;
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      for (int n = 0; n < 64 && !done; n++) begin
         @(posedge aclk);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid) begin
            done = 1'b1;
            `CHK("rdata", rsp.rdata, {24'h000000, e})
            `CHK("rresp", rsp.rresp, er)
         end
      end
      if (!done) begin
         failures++;
         print_verdict();
      end
   endtask

   task automatic pins(input logic [7:0] oe, input logic [7:0] po);
      idle(2);
      `CHK("pin_oe", pin_oe, oe)
      `CHK("pin_out", pin_out, po)
   endtask

   // ==========================================
   // main sequence
   initial begin
      aresetn = 1'b0;
      req = '0;
      periph = '0;
      ext_en = 8'h00;
      ext_val = 8'h00;
      failures = 0;
      samples_checked = 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      `CHK("pin_oe", pin_oe, 8'h00)
      `CHK("pullup_on", pullup_on, 8'h00)
      @(posedge aclk);
      for (int i = 0; i < 5; i++) rd(rst_addr[i], rst_val[i]);
      rd(8'h18, 8'h00, RESP_SLVERR);
      wr(8'h18, 8'hFF, 4'h1, RESP_SLVERR);
      ext_en <= 8'hFF;
      ext_val <= 8'hA5;
      wr(OFF_ANSEL, 8'h00);
      idle(4);
      rd(OFF_DATA, 8'hA1);
      `CHK("flag", flag, 1'b0)
      wr(OFF_ANSEL, 8'h72);
      rd(OFF_DATA, 8'h81);
      wr(OFF_ANSEL, 8'h02);
      wr(OFF_DATA, 8'hFF);
      wr(OFF_DIR, 8'h0C);
      rd(OFF_DIR, 8'h00);
      pins(8'hF2, 8'hF2);
      idle(4);
      rd(OFF_DATA, 8'hF1);
      wr(OFF_DATA, 8'h00);
      pins(8'hF3, 8'h00);
      wr(OFF_DATA, 8'hFF);
      periph <= '{en: 8'h93, val: 8'h00};
      pins(8'hF3, 8'h60);
      periph <= '{en: 8'h93, val: 8'h93};
      pins(8'hF2, 8'hF2);
      periph <= '0;
      wr(OFF_DIR, 8'hFF);
      idle(2);
      `CHK("pin_oe", pin_oe, 8'h00)
      wr(OFF_ANSEL, 8'h00);
      idle(4);
      wr(OFF_DATA, 8'h00, 4'h0);
      wr(OFF_DIR, 8'h00);
      pins(8'hF2, 8'hA0);
      wr(OFF_DIR, 8'hFF);
      wr(OFF_ANSEL, 8'h02);
      idle(2);
      `CHK("pullup_on", pullup_on, 8'h00)
      wr(OFF_CTRL, 8'h00);
      idle(2);
      `CHK("pullup_on", pullup_on, 8'hF0)
      wr(OFF_DIR, 8'h03);
      idle(2);
      `CHK("pullup_on", pullup_on, 8'h00)
      wr(OFF_DIR, 8'hFF);
      wr(OFF_IOC, 8'h10);
      idle(4);
      rd(OFF_DATA, 8'hA1);
      `CHK("flag", flag, 1'b0)
      ext_val <= 8'hB5;
      idle(4);
      `CHK("flag", flag, 1'b1)
      rd(OFF_CTRL, 8'h02);
      wr(OFF_CTRL, 8'h02);
      idle(2);
      `CHK("flag", flag, 1'b1)
      rd(OFF_DATA, 8'hB1);
      wr(OFF_CTRL, 8'h02);
      idle(2);
      `CHK("flag", flag, 1'b0)
      print_verdict();
   end
endmodule
`default_nettype wire
